/* rtl/pss_pkg.sv */
// constants and types shared by the system sequencer files
package pss_pkg;
	// clock rate and reset period
	localparam longint PSS_CLOCK_HZ = 40000000;
	localparam int PSS_RESET_TIME_MS = 260;
	localparam int PSS_RESET_CYCLES = int'((PSS_CLOCK_HZ * PSS_RESET_TIME_MS) / 1000);
	// width of the reset period counter
	localparam int PSS_TIMER_W = 24;
	// startup variants
	typedef enum logic [1:0] {
		PSS_VAR_A = 2'h0,
		PSS_VAR_B = 2'h1,
		PSS_VAR_C = 2'h2
	} pss_variant_t;
	// sequencer states
	typedef enum logic [2:0] {
		PSS_OFF = 3'h0,
		PSS_RAMP = 3'h1,
		PSS_RESET = 3'h2,
		PSS_WAIT_HOST = 3'h3,
		PSS_ON = 3'h4
	} pss_state_t;
	// status bit positions: button state and button interrupt unmask
	localparam int PSS_BTN_STATE_BIT = 0;
	localparam int PSS_BTN_UNMASK_BIT = 1;
	// reset value of the button interrupt unmask bit
	localparam logic PSS_BTN_UNMASK_RST = 1'h1;
endpackage

/* rtl/pss_sync.sv */
// two flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module pss_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_one; // read only by stage two
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_sync;
	// next values: plain shift
	always_comb
	begin
		next_stage_one = async_in;
		next_sync = stage_one;
	end
	// registers
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			stage_one <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage_one <= next_stage_one;
			sync_out <= next_sync;
		end
	end
endmodule // pss_sync

/* rtl/pss_timer.sv */
// reset period down counter: start pulse, done level
`timescale 1ns/1ps
module pss_timer
	import pss_pkg::*;
#(
	parameter logic [PSS_TIMER_W-1:0] PERIOD = PSS_TIMER_W'(PSS_RESET_CYCLES)
) (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic start_in,
	output logic done_out
);
	logic [PSS_TIMER_W-1:0] count; // cycles left
	logic [PSS_TIMER_W-1:0] next_count;
	logic next_done;
	// a restart reloads even while running, so a held reset extends the period
	always_comb
	begin
		next_count = count;
		next_done = done_out;
		if (start_in)
		begin
			next_count = PERIOD;
			next_done = 1'b0;
		end
		else if (count > 1)
		begin
			next_count = count - 1'b1;
		end
		else if (count == 1)
		begin
			next_count = '0;
			next_done = 1'b1;
		end
	end
	// registers
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			count <= '0;
			done_out <= 1'b0;
		end
		else
		begin
			count <= next_count;
			done_out <= next_done;
		end
	end
endmodule // pss_timer

/* rtl/pss_sequencer.sv */
// system sequencer: startup order, host reset, button interrupt, thermal cutoff
`timescale 1ns/1ps
module pss_sequencer
	import pss_pkg::*;
#(
	parameter logic [PSS_TIMER_W-1:0] RESET_CYCLES = PSS_TIMER_W'(PSS_RESET_CYCLES),
	parameter pss_variant_t VARIANT = PSS_VAR_A
) (
	input wire logic clock_in,
	input wire logic resetn_in, // supply undervoltage reset
	input wire logic button_press_in, // pressed through the series resistor
	input wire logic button_short_in, // shorted straight to ground
	input wire logic enable_in_first,
	input wire logic enable_in_second,
	input wire logic enable_in_third,
	input wire logic enable_in_fourth,
	input wire logic buck_one_in_regulation_in,
	input wire logic buck_one_output_in_window_in,
	input wire logic over_temp_in, // hot flag with its own cool-down hysteresis
	input wire logic charger_input_supply_valid_in,
	input wire logic fault_in, // unmasked fault present
	input wire logic host_read_in, // one-cycle pulse on host register read
	input wire logic button_irq_unmask_in,
	output logic buck_one_en_out,
	output logic buck_two_en_out,
	output logic buck_three_en_out,
	output logic boost_backlight_en_out,
	output logic host_reset_out_n,
	output logic host_reset_oe_out,
	output logic host_irq_out_n,
	output logic host_irq_oe_out,
	output logic button_state_flag_out,
	output logic system_on_out
);
	////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	// the button pin is asynchronous to the oscillator clock, so both of its
	// indications cross through two flip-flops before any decision reads them;
	// the cost is a two-cycle lag on every press, release and short
	logic [1:0] btn_sync; // [1] short, [0] press
	logic press;
	logic short_gnd;
	pss_sync #(.WIDTH(2)) u_btn_sync (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.async_in({button_short_in, button_press_in}),
		.sync_out(btn_sync)
	);
	// a hard short also pulls through the resistor path, so it counts as a press
	assign press = btn_sync[0] | btn_sync[1];
	assign short_gnd = btn_sync[1];
	// other indications come from logic on this clock, so no synchroniser
	logic [3:0] enables;
	logic any_enable;
	// bit n of enables is the host's request for regulator n+1
	assign enables = {enable_in_fourth, enable_in_third, enable_in_second, enable_in_first};
	assign any_enable = |enables;

	////////////////////////////////////////////////////////////////////////
	// reset timer
	// one shared down counter serves the startup period, the period restarted
	// after an out-of-window expiry and the period that follows a hard short;
	// it is reloaded on any start pulse, so the last start always sets the end
	logic timer_start;
	logic timer_done;
	// the period length is a parameter so a bench may shorten it
	pss_timer #(.PERIOD(RESET_CYCLES)) u_timer (
		.clock_in(clock_in),
		.resetn_in(resetn_in),
		.start_in(timer_start),
		.done_out(timer_done)
	);

	////////////////////////////////////////////////////////////////////////
	// sequencer state
	// off: all regulators off, waiting for a start condition
	// ramp: buck one soft-starting, host reset held low
	// reset: host reset held low while the period runs
	// wait_host: reset released, button (or charger) must hold until the host claims
	// on: host owns the enables; the last enable dropping powers down
	pss_state_t state;
	pss_state_t next_state;
	logic [2:0] boot_en; // startup forced enables of the three bucks
	logic [2:0] next_boot_en;
	logic start_cond;
	logic hold_cond; // what keeps startup alive before the host takes over
	// start and hold conditions per variant; only the third variant lets a
	// valid charger input stand in for the button
	always_comb
	begin
		start_cond = press;
		hold_cond = press;
		if (VARIANT == PSS_VAR_C)
		begin
			start_cond = press | charger_input_supply_valid_in;
			hold_cond = press | charger_input_supply_valid_in;
		end
	end
	// next state and startup enables
	always_comb
	begin
		next_state = state;
		next_boot_en = boot_en;
		timer_start = 1'b0;
		case (state)
			PSS_OFF:
			begin
				next_boot_en = 3'h0;
				// a start while hot is refused; the thermal flag carries its own hysteresis
				if (start_cond && !over_temp_in)
				begin
					next_state = PSS_RAMP;
					if (VARIANT == PSS_VAR_B)
						next_boot_en = 3'h7;
					else
						next_boot_en = 3'h1;
				end
			end
			PSS_RAMP:
			begin
				// without button, charger or an enable the ramp is abandoned
				if (!hold_cond && !any_enable)
					next_state = PSS_OFF;
				else if (buck_one_in_regulation_in)
				begin
					next_state = PSS_RESET;
					timer_start = 1'b1;
					if (VARIANT == PSS_VAR_A)
						next_boot_en = 3'h7;
				end
			end
			PSS_RESET:
			begin
				// expiry with the output out of window restarts the period
				if (!hold_cond && !any_enable)
					next_state = PSS_OFF;
				else if (timer_done && buck_one_output_in_window_in)
					next_state = PSS_WAIT_HOST;
				else if (timer_done)
					timer_start = 1'b1;
			end
			PSS_WAIT_HOST:
			begin
				// host must take over while the button is held
				if (any_enable)
				begin
					next_state = PSS_ON;
					next_boot_en = 3'h0;
				end
				else if (!hold_cond)
					next_state = PSS_OFF;
			end
			PSS_ON:
			begin
				// the button no longer matters here; the host alone decides
				next_boot_en = 3'h0;
				if (!any_enable)
					next_state = PSS_OFF;
			end
			default:
			begin
				// unused codes fall back to off
				next_state = PSS_OFF;
				next_boot_en = 3'h0;
			end
		endcase
		// thermal cutoff overrides everything; restart waits for cool-down
		if (over_temp_in)
		begin
			next_state = PSS_OFF;
			next_boot_en = 3'h0;
		end
		// a hard short restarts the period and keeps restarting it while held
		if (short_gnd && state != PSS_OFF && !over_temp_in)
			timer_start = 1'b1;
	end
	// registers
	// undervoltage reset returns straight to off with all startup enables clear
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state <= PSS_OFF;
			boot_en <= 3'h0;
		end
		else
		begin
			state <= next_state;
			boot_en <= next_boot_en;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// regulator enables and host reset
	// enables and reset level are worked out from next_state so that they land on
	// the same edge as the state change; this costs a longer combinational path
	// but keeps every output a plain flip-flop with no extra cycle of lag
	logic [3:0] next_reg_en;
	logic next_reset_n;
	// the hold flag outlives the short: it clears only on the first cycle after expiry with buck one in its window
	logic reset_hold; // short seen since last expiry
	logic next_reset_hold;
	logic alive;
	assign alive = (next_state != PSS_OFF);
	always_comb
	begin
		next_reg_en = 4'h0;
		if (alive)
			next_reg_en = enables | {1'b0, boot_en | next_boot_en};
		next_reset_hold = reset_hold;
		if (short_gnd)
			next_reset_hold = 1'b1;
		// a hard-reset release also waits for buck one to be back in its window
		else if (timer_done && !timer_start && buck_one_output_in_window_in)
			next_reset_hold = 1'b0;
		// low in startup, during a short and until the period ends in window
		next_reset_n = 1'b0;
		if ((next_state == PSS_WAIT_HOST || next_state == PSS_ON) && !next_reset_hold && !short_gnd)
			next_reset_n = 1'b1;
	end
	// output registers; the open-drain enables mirror the inverted level
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			buck_one_en_out <= 1'b0;
			buck_two_en_out <= 1'b0;
			buck_three_en_out <= 1'b0;
			boost_backlight_en_out <= 1'b0;
			host_reset_out_n <= 1'b0;
			host_reset_oe_out <= 1'b1;
			reset_hold <= 1'b0;
			system_on_out <= 1'b0;
		end
		else
		begin
			buck_one_en_out <= next_reg_en[0];
			buck_two_en_out <= next_reg_en[1];
			buck_three_en_out <= next_reg_en[2];
			boost_backlight_en_out <= next_reg_en[3];
			host_reset_out_n <= next_reset_n;
			host_reset_oe_out <= ~next_reset_n; // open drain: drive only low
			reset_hold <= next_reset_hold;
			system_on_out <= alive;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt and button status
	// the button part of the interrupt is a pure level and needs no clear;
	// the fault part is latched so a short fault is not lost before the host
	// gets round to reading; the unmask input only gates the button part
	logic fault_pend; // latched fault, cleared by host read
	logic next_fault_pend;
	logic next_irq_n;
	always_comb
	begin
		// a fault in the read cycle wins over the clear
		next_fault_pend = fault_pend;
		if (host_read_in)
			next_fault_pend = 1'b0;
		if (fault_in)
			next_fault_pend = 1'b1;
		// button part follows the pin level, so release clears it itself
		next_irq_n = !((press && button_irq_unmask_in) || next_fault_pend);
	end
	// interrupt, its drive enable and the button status bit
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			fault_pend <= 1'b0;
			host_irq_out_n <= 1'b1;
			host_irq_oe_out <= 1'b0;
			button_state_flag_out <= 1'b0;
		end
		else
		begin
			fault_pend <= next_fault_pend;
			host_irq_out_n <= next_irq_n;
			host_irq_oe_out <= ~next_irq_n;
			button_state_flag_out <= press;
		end
	end
endmodule // pss_sequencer

/* test/pss_sequencer_asserts.sv */
// concurrent checks on the system sequencer ports
`timescale 1ns/1ps
module pss_sequencer_asserts #(
	parameter int RESET_CYCLES = 20 // reset period in clocks
) (
	input wire logic clock_in,
	input wire logic resetn_in,
	input wire logic button_short_in,
	input wire logic enable_in_first,
	input wire logic enable_in_second,
	input wire logic enable_in_third,
	input wire logic enable_in_fourth,
	input wire logic over_temp_in,
	input wire logic button_irq_unmask_in,
	input wire logic buck_one_output_in_window_in,
	input wire logic buck_one_en_out,
	input wire logic buck_two_en_out,
	input wire logic buck_three_en_out,
	input wire logic boost_backlight_en_out,
	input wire logic host_reset_out_n,
	input wire logic host_irq_out_n,
	input wire logic button_state_flag_out,
	input wire logic system_on_out
);
	int lo_cnt; // length of the current low stretch of host reset
	// count low cycles so a release can be judged against the period
	always_ff @(posedge clock_in or negedge resetn_in)
	begin
		if (!resetn_in)
			lo_cnt <= 0;
		else
			lo_cnt <= host_reset_out_n ? 0 : lo_cnt + 1;
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);
	////////////////////////////////////////////////////////////////
	property p_hot_off;
		over_temp_in |=> !(buck_one_en_out || buck_two_en_out || buck_three_en_out || boost_backlight_en_out);
	endproperty
	a_hot_off: assert property (p_hot_off) else $error("regulator on while hot");
	property p_boost_follow;
		!enable_in_fourth |=> !boost_backlight_en_out;
	endproperty
	a_boost_follow: assert property (p_boost_follow) else $error("boost on without its enable");
	property p_two_on;
		system_on_out && enable_in_second && !over_temp_in |=> buck_two_en_out;
	endproperty
	a_two_on: assert property (p_two_on) else $error("second buck ignores its enable");
	property p_stay_on;
		system_on_out && !over_temp_in && (enable_in_first || enable_in_second || enable_in_third || enable_in_fourth)
			|=> system_on_out;
	endproperty
	a_stay_on: assert property (p_stay_on) else $error("system dropped with an enable held");
	property p_irq_btn;
		$rose(button_state_flag_out) && button_irq_unmask_in |-> ##[0:2] !host_irq_out_n;
	endproperty
	a_irq_btn: assert property (p_irq_btn) else $error("button press gave no interrupt");
	property p_short_rst;
		system_on_out && button_short_in |-> ##[1:3] !host_reset_out_n;
	endproperty
	a_short_rst: assert property (p_short_rst) else $error("hard short left reset high");
	property p_rst_win;
		$rose(host_reset_out_n) |-> $past(buck_one_output_in_window_in);
	endproperty
	a_rst_win: assert property (p_rst_win) else $error("reset released out of window");
	property p_rst_len;
		$rose(host_reset_out_n) |-> lo_cnt >= RESET_CYCLES;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset released too early");
endmodule // pss_sequencer_asserts

/* test/pss_host_model.sv */
// host processor and buck one feedback seen by the sequencer
`timescale 1ns/1ps
module pss_host_model #(
	parameter int RAMP_CYCLES = 4 // buck one soft-start length
) (
	input wire logic clock_in,
	input wire logic buck_one_en_in,
	input wire logic reset_line_in, // resolved open-drain level
	input wire logic window_ok_in, // bench can spoil the output window
	input wire logic take_ctrl_in, // bench lets the host claim the rails
	output logic in_regulation_out = 1'b0,
	output logic in_window_out = 1'b0,
	output logic enable_first_out = 1'b0
);
	int ramp = 0; // cycles since buck one was enabled
	// feedback appears only after soft start; host claims once out of reset
	always @(posedge clock_in)
	begin
		ramp <= buck_one_en_in ? ramp + 1 : 0;
		in_regulation_out <= buck_one_en_in && ramp >= RAMP_CYCLES;
		in_window_out <= buck_one_en_in && ramp >= RAMP_CYCLES && window_ok_in;
		// once claimed the enable is kept, so a hard reset does not power down
		enable_first_out <= take_ctrl_in && (enable_first_out || reset_line_in);
	end
endmodule // pss_host_model

/* test/pss_sequencer_tb_top.sv */
// self-checking bench for the system sequencer, all three variants
`timescale 1ns/1ps
module pss_sequencer_tb_top;
	import pss_pkg::*;
	localparam int RST_CYC = 20; // shortened reset period
	logic clock_in = 1'b0, resetn_in = 1'b0, button_press_in = 1'b0, button_short_in = 1'b0;
	logic enable_in_second = 1'b0, enable_in_third = 1'b0, enable_in_fourth = 1'b0;
	logic over_temp_in = 1'b0, fault_in = 1'b0, host_read_in = 1'b0, button_irq_unmask_in = 1'b1;
	logic window_ok = 1'b1, take_ctrl = 1'b0;
	logic en1, in_reg, in_win, b1, b2, b3, b4, rst_n, rst_oe, irq_n, irq_oe, flag, sys_on;
	logic chg_ok = 1'b0, reg_x = 1'b0, rst_b, rst_c, sys_b, sys_c;
	logic [3:0] en_b, en_c;
	int n_fail = 0, num_checks = 0, cycles = 0;
	wire rst_line = rst_oe ? 1'b0 : 1'b1; // pulled up when released
	wire irq_line = irq_oe ? 1'b0 : 1'b1;
	pss_sequencer #(.RESET_CYCLES(PSS_TIMER_W'(RST_CYC)), .VARIANT(PSS_VAR_A)) u_pss_sequencer (
		.clock_in(clock_in), .resetn_in(resetn_in), .button_press_in(button_press_in),
		.button_short_in(button_short_in), .enable_in_first(en1), .enable_in_second(enable_in_second),
		.enable_in_third(enable_in_third), .enable_in_fourth(enable_in_fourth),
		.buck_one_in_regulation_in(in_reg), .buck_one_output_in_window_in(in_win),
		.over_temp_in(over_temp_in), .charger_input_supply_valid_in(1'b0), .fault_in(fault_in),
		.host_read_in(host_read_in), .button_irq_unmask_in(button_irq_unmask_in),
		.buck_one_en_out(b1), .buck_two_en_out(b2), .buck_three_en_out(b3), .boost_backlight_en_out(b4),
		.host_reset_out_n(rst_n), .host_reset_oe_out(rst_oe), .host_irq_out_n(irq_n),
		.host_irq_oe_out(irq_oe), .button_state_flag_out(flag), .system_on_out(sys_on));
	pss_host_model u_pss_host_model (.clock_in(clock_in), .buck_one_en_in(b1), .reset_line_in(rst_line),
		.window_ok_in(window_ok), .take_ctrl_in(take_ctrl), .in_regulation_out(in_reg),
		.in_window_out(in_win), .enable_first_out(en1));
	// second and third variants share the button; the bench plays their buck one feedback
	pss_sequencer #(.RESET_CYCLES(PSS_TIMER_W'(RST_CYC)), .VARIANT(PSS_VAR_B)) u_pss_sequencer_b (
		.clock_in(clock_in), .resetn_in(resetn_in), .button_press_in(button_press_in), .button_short_in(1'b0),
		.enable_in_first(1'b0), .enable_in_second(1'b0), .enable_in_third(1'b0), .enable_in_fourth(1'b0),
		.buck_one_in_regulation_in(reg_x), .buck_one_output_in_window_in(reg_x), .over_temp_in(1'b0),
		.charger_input_supply_valid_in(1'b0), .fault_in(1'b0), .host_read_in(1'b0), .button_irq_unmask_in(1'b1),
		.buck_one_en_out(en_b[0]), .buck_two_en_out(en_b[1]), .buck_three_en_out(en_b[2]),
		.boost_backlight_en_out(en_b[3]), .host_reset_out_n(rst_b), .host_reset_oe_out(), .host_irq_out_n(),
		.host_irq_oe_out(), .button_state_flag_out(), .system_on_out(sys_b));
	pss_sequencer #(.RESET_CYCLES(PSS_TIMER_W'(RST_CYC)), .VARIANT(PSS_VAR_C)) u_pss_sequencer_c (
		.clock_in(clock_in), .resetn_in(resetn_in), .button_press_in(button_press_in), .button_short_in(1'b0),
		.enable_in_first(1'b0), .enable_in_second(1'b0), .enable_in_third(1'b0), .enable_in_fourth(1'b0),
		.buck_one_in_regulation_in(reg_x), .buck_one_output_in_window_in(reg_x), .over_temp_in(1'b0),
		.charger_input_supply_valid_in(chg_ok), .fault_in(1'b0), .host_read_in(1'b0), .button_irq_unmask_in(1'b1),
		.buck_one_en_out(en_c[0]), .buck_two_en_out(en_c[1]), .buck_three_en_out(en_c[2]),
		.boost_backlight_en_out(en_c[3]), .host_reset_out_n(rst_c), .host_reset_oe_out(), .host_irq_out_n(),
		.host_irq_oe_out(), .button_state_flag_out(), .system_on_out(sys_c));
	initial forever #12.5 clock_in = ~clock_in;
	// run ceiling well above the few hundred cycles the scenarios take
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_fail++;
			tally_and_finish;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic got, input logic exp);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_in);
		#2;
	endtask
	// bounded wait for host reset to be released
	task automatic rise_wait(output int n);
		n = 0;
		while (rst_line !== 1'b1 && n < 200)
		begin
			cyc(1);
			n++;
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// press, ramp, spoilt window, release, host takes over
	task automatic s_startup;
		int n;
		window_ok = 1'b0;
		take_ctrl = 1'b1;
		button_press_in = 1'b1;
		cyc(4);
		chk(b1, 1'b1);
		chk(b2, 1'b0);
		cyc(10);
		chk(b2 & b3, 1'b1);
		cyc(2 * RST_CYC + 6);
		chk(rst_line, 1'b0);
		window_ok = 1'b1;
		rise_wait(n);
		chk(rst_line, 1'b1);
		cyc(3);
		button_press_in = 1'b0;
		cyc(5);
		chk(sys_on & b1, 1'b1);
		chk(b2, 1'b0);
		enable_in_fourth = 1'b1;
		cyc(2);
		chk(b4, 1'b1);
		enable_in_fourth = 1'b0;
	endtask
	// button interrupt, masked press, latched fault
	task automatic s_irq;
		button_press_in = 1'b1;
		cyc(5);
		chk(flag, 1'b1);
		chk(irq_line, 1'b0);
		button_press_in = 1'b0;
		cyc(5);
		chk(irq_line, 1'b1);
		button_irq_unmask_in = 1'b0;
		button_press_in = 1'b1;
		cyc(5);
		chk(irq_line, 1'b1);
		button_press_in = 1'b0;
		button_irq_unmask_in = 1'b1;
		fault_in = 1'b1;
		cyc(1);
		fault_in = 1'b0;
		cyc(6);
		chk(irq_line, 1'b0);
		host_read_in = 1'b1;
		cyc(1);
		host_read_in = 1'b0;
		cyc(3);
		chk(irq_line, 1'b1);
	endtask
	// hard short holds reset for its duration plus one period
	task automatic s_short;
		int n;
		button_short_in = 1'b1;
		cyc(RST_CYC + 5);
		chk(rst_line, 1'b0);
		button_short_in = 1'b0;
		rise_wait(n);
		chk(n >= RST_CYC && rst_line === 1'b1, 1'b1);
	endtask
	// one enable keeps the system up, dropping all turns it off
	task automatic s_shutdown;
		enable_in_third = 1'b1;
		take_ctrl = 1'b0;
		cyc(3);
		chk(sys_on & b3 & ~b1, 1'b1);
		enable_in_third = 1'b0;
		cyc(3);
		chk(sys_on | b1 | b3, 1'b0);
	endtask
	// release before the host claims control, then heat during ramp
	task automatic s_early_and_hot;
		button_press_in = 1'b1;
		cyc(6);
		button_press_in = 1'b0;
		cyc(6);
		chk(sys_on | b1, 1'b0);
		button_press_in = 1'b1;
		enable_in_fourth = 1'b1;
		cyc(4);
		over_temp_in = 1'b1;
		cyc(6);
		chk(sys_on | b1 | b2 | b3 | b4, 1'b0);
		over_temp_in = 1'b0;
		button_press_in = 1'b0;
		enable_in_fourth = 1'b0;
	endtask
	// second variant starts three bucks at once; third starts buck one alone, on charger or button
	task automatic s_variants;
		cyc(4);
		chg_ok = 1'b1;
		cyc(2);
		chk(en_c[0] & ~sys_b, 1'b1);
		button_press_in = 1'b1;
		cyc(4);
		chk(en_b[2:0] == 3'h7, 1'b1);
		chk(en_c[2:0] == 3'h1, 1'b1);
		reg_x = 1'b1;
		cyc(3);
		chk(rst_b | rst_c, 1'b0);
		cyc(RST_CYC + 2);
		chk(rst_b & rst_c, 1'b1);
		chk(en_c[2:0] == 3'h1, 1'b1);
		button_press_in = 1'b0;
		cyc(4);
		chk(sys_b, 1'b0);
		chk(sys_c, 1'b1);
		chg_ok = 1'b0;
		reg_x = 1'b0;
		cyc(2);
		chk(sys_c, 1'b0);
	endtask
	initial
	begin
		cyc(6);
		resetn_in = 1'b1;
		cyc(2);
		chk(rst_line | ~irq_line | sys_on, 1'b0);
		s_startup;
		s_irq;
		s_short;
		s_shutdown;
		s_early_and_hot;
		s_variants;
		tally_and_finish;
	end
endmodule // pss_sequencer_tb_top
bind pss_sequencer pss_sequencer_asserts #(.RESET_CYCLES(RESET_CYCLES)) u_pss_sequencer_asserts (.clock_in,
	.resetn_in, .button_short_in, .enable_in_first, .enable_in_second, .enable_in_third, .enable_in_fourth,
	.over_temp_in, .button_irq_unmask_in, .buck_one_output_in_window_in, .buck_one_en_out, .buck_two_en_out,
	.buck_three_en_out, .boost_backlight_en_out, .host_reset_out_n, .host_irq_out_n, .button_state_flag_out,
	.system_on_out);
